// ### shared/dws_regs.vh
/*
 * Constants of the write, precharge and self-refresh command engine:
 * command codes, burst-length field encodings, beat counts and timing.
 * Assumes inclusion by bare name from the design files under logic/.
 */
`ifndef DWS_REGS_VH
`define DWS_REGS_VH

// Command codes as {RAS#, CAS#, WE#} with chip select low.
`define DWS_CMD_ACT 3'h3
`define DWS_CMD_WR 3'h4
`define DWS_CMD_PRE 3'h2
`define DWS_CMD_REF 3'h1

// Burst-length field encodings.
`define DWS_BL_FIX8 2'h0
`define DWS_BL_OTF 2'h1
`define DWS_BL_FIX4 2'h2

// Beats per burst.
`define DWS_BEATS_BL8 4'h8
`define DWS_BEATS_BC4 4'h4

// System clock rate and internal self-refresh interval.
`define DWS_MCLK_MHZ 40
`define DWS_TREFI_NS 7800

`endif

// ### logic/dws_core.v
/*
 * Device-side command engine: write burst capture, bank precharge and
 * self refresh, plus the FIFO that carries captured write beats out.
 * Assumes every pin input is asynchronous to MCLK and that the link clock
 * CK runs several times slower than MCLK so its edges can be found.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dws_regs.vh"

module dws_fifo #(
    parameter W = 8,
    parameter D = 4,
    parameter AW = 2
)
(
    // Clock and control.
    input wire clk,
    input wire rst_n,
    input wire ce,
    // Filling side.
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Draining side.
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != D[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = ce & in_valid & in_ready;
    assign pop = ce & out_valid & out_ready;

    // Data storage carries no reset; only the pointers and the count need a defined value.
    always @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end
endmodule

module dws_core #(
    parameter DQ_W = 8,
    parameter FIFO_D = 4,
    parameter REFI_NS = `DWS_TREFI_NS
)
(
    // System clock, enable and reset.
    input wire MCLK,
    input wire RESETN,
    input wire CE,
    // Link pins from the controller.
    input wire CK,
    input wire CKE,
    input wire CS_N,
    input wire RAS_N,
    input wire CAS_N,
    input wire WE_N,
    input wire A10,
    input wire A12,
    input wire [2:0] COL,
    input wire [2:0] BA,
    input wire DQS,
    input wire [DQ_W-1:0] DQ,
    // Mode settings.
    input wire [1:0] BL_FIELD,
    input wire [3:0] ADD_LAT,
    input wire [3:0] CAS_WR_LAT,
    // Captured write beats.
    output reg WR_VALID,
    input wire WR_READY,
    output reg [DQ_W+2:0] WR_DATA,
    // Status.
    output reg [7:0] BANK_OPEN,
    output reg SELF_REFRESH,
    output reg DLL_ENABLE,
    output reg DLL_RESET,
    output reg INT_REFRESH,
    output reg CMD_ERROR,
    output reg BURST_CHOP,
    output reg OVERRUN
);
    localparam PW = 15 + DQ_W;
    localparam REFI_CYC = (REFI_NS * `DWS_MCLK_MHZ) / 1000;

    reg rst_s1;
    reg rst_s2;
    reg [PW-1:0] pin_s1;
    reg [PW-1:0] pin_s2;
    reg ck_d;
    reg dqs_d;
    reg cke_prev;
    reg [1:0] slot_v;
    reg [4:0] slot_cnt [0:1];
    reg [2:0] slot_col [0:1];
    reg [1:0] slot_chop;
    reg act_on;
    reg [3:0] act_beat;
    reg [2:0] act_col;
    reg act_chop;
    reg push_v;
    reg [DQ_W+2:0] push_d;
    reg [15:0] refi_cnt;
    reg due;
    reg [2:0] due_col;
    reg due_chop;
    integer i;
    integer j;
    wire rst_n;
    wire s_ck;
    wire s_cke;
    wire s_cs_n;
    wire [2:0] s_cmd;
    wire s_a10;
    wire s_a12;
    wire [2:0] s_col;
    wire [2:0] s_ba;
    wire s_dqs;
    wire [DQ_W-1:0] s_dq;
    wire ck_rise;
    wire dqs_edge;
    wire [4:0] wlat;
    wire new_chop;
    wire fifo_ready;
    wire fifo_valid;
    wire [DQ_W+2:0] fifo_data;
    wire take_out;
    wire [2:0] dcol;
    wire dchop;

    // Column of beat n: eight-beat bursts wrap over all eight, chops in the half.
    function [2:0] beat_col;
        input [2:0] col;
        input [3:0] n;
        input chop;
        begin
            if (chop)
                beat_col = {col[2], col[1:0] + n[1:0]};
            else
                beat_col = col + n[2:0];
        end
    endfunction

    // A command is taken only with chip select low.
    function is_cmd;
        input cs_n;
        input [2:0] cmd;
        input [2:0] code;
        begin
            is_cmd = ~cs_n & (cmd == code);
        end
    endfunction

    assign rst_n = rst_s2;
    assign {s_ck, s_cke, s_cs_n} = pin_s2[PW-1:PW-3];
    assign s_cmd = pin_s2[PW-4:PW-6];
    assign {s_a10, s_a12, s_col, s_ba, s_dqs} = pin_s2[PW-7:DQ_W];
    assign s_dq = pin_s2[DQ_W-1:0];
    assign ck_rise = s_ck & ~ck_d;
    assign dqs_edge = s_dqs ^ dqs_d;
    assign wlat = {1'b0, ADD_LAT} + {1'b0, CAS_WR_LAT};
    assign new_chop = (BL_FIELD == `DWS_BL_FIX4) | ((BL_FIELD == `DWS_BL_OTF) & ~s_a12);
    assign take_out = ~WR_VALID | WR_READY;
    // A burst falling due takes over the beat context from the active one.
    assign dcol = due ? due_col : act_col;
    assign dchop = due ? due_chop : act_chop;

    // Reset release through two flops; assertion stays asynchronous.
    always @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // Two-flop synchroniser for every pin; all pins share one delay so the
    // strobe and data keep their relation to CK.
    always @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1 <= {PW{1'b0}};
            pin_s2 <= {PW{1'b0}};
        end
        else if (CE)
        begin
            pin_s1 <= {CK, CKE, CS_N, RAS_N, CAS_N, WE_N, A10, A12, COL, BA, DQS, DQ};
            pin_s2 <= pin_s1;
        end
    end

    // Pick the write slot that falls due on this CK edge.
    always @*
    begin
        due = 1'b0;
        due_col = 3'h0;
        due_chop = 1'b0;
        for (j = 0; j < 2; j = j + 1)
        begin
            if (ck_rise && slot_v[j] && slot_cnt[j] == 5'h01)
            begin
                due = 1'b1;
                due_col = slot_col[j];
                due_chop = slot_chop[j];
            end
        end
    end

    // Command engine, burst capture and self refresh.
    always @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ck_d <= 1'b0;
            dqs_d <= 1'b0;
            cke_prev <= 1'b0;
            slot_v <= 2'h0;
            slot_cnt[0] <= 5'h00;
            slot_cnt[1] <= 5'h00;
            slot_col[0] <= 3'h0;
            slot_col[1] <= 3'h0;
            slot_chop <= 2'h0;
            act_on <= 1'b0;
            act_beat <= 4'h0;
            act_col <= 3'h0;
            act_chop <= 1'b0;
            push_v <= 1'b0;
            push_d <= {(DQ_W+3){1'b0}};
            refi_cnt <= 16'h0000;
            BANK_OPEN <= 8'h00;
            SELF_REFRESH <= 1'b0;
            DLL_ENABLE <= 1'b1;
            DLL_RESET <= 1'b0;
            INT_REFRESH <= 1'b0;
            CMD_ERROR <= 1'b0;
            BURST_CHOP <= 1'b0;
            OVERRUN <= 1'b0;
        end
        else if (CE)
        begin
            ck_d <= s_ck;
            dqs_d <= s_dqs;
            push_v <= 1'b0;
            DLL_RESET <= 1'b0;
            INT_REFRESH <= 1'b0;
            CMD_ERROR <= 1'b0;
            // A full FIFO cannot stall the controller, so a lost beat is flagged.
            if (push_v && !fifo_ready)
                OVERRUN <= 1'b1;
            if (ck_rise)
                cke_prev <= s_cke;
            // Latency slots count CK edges; a slot reaching one starts the burst.
            if (ck_rise)
            begin
                for (i = 0; i < 2; i = i + 1)
                begin
                    if (slot_v[i])
                    begin
                        slot_cnt[i] <= slot_cnt[i] - 5'h01;
                        if (slot_cnt[i] == 5'h01)
                            slot_v[i] <= 1'b0;
                    end
                end
            end
            // Strobe edges while a burst is active carry one beat each.
            if ((act_on || due) && dqs_edge)
            begin
                push_v <= 1'b1;
                push_d <= {beat_col(dcol, due ? 4'h0 : act_beat, dchop), s_dq};
                act_col <= dcol;
                act_chop <= dchop;
                act_beat <= (due ? 4'h0 : act_beat) + 4'h1;
                act_on <= ((due ? 4'h1 : act_beat + 4'h1) !=
                    (dchop ? `DWS_BEATS_BC4 : `DWS_BEATS_BL8));
            end
            else if (due)
            begin
                // A following burst takes over straight after the last beat.
                act_on <= 1'b1;
                act_beat <= 4'h0;
                act_col <= due_col;
                act_chop <= due_chop;
            end
            if (SELF_REFRESH)
            begin
                // Only CKE is looked at; exit is taken on the first CK edge
                // with CKE high and restarts the delay-locked loop.
                if (ck_rise && s_cke)
                begin
                    SELF_REFRESH <= 1'b0;
                    DLL_ENABLE <= 1'b1;
                    DLL_RESET <= 1'b1;
                end
                if (refi_cnt == 16'h0000)
                begin
                    INT_REFRESH <= 1'b1;
                    refi_cnt <= REFI_CYC[15:0] - 16'h0001;
                end
                else
                    refi_cnt <= refi_cnt - 16'h0001;
            end
            else if (ck_rise)
            begin
                if (is_cmd(s_cs_n, s_cmd, `DWS_CMD_REF) && cke_prev && !s_cke)
                begin
                    SELF_REFRESH <= 1'b1;
                    DLL_ENABLE <= 1'b0;
                    refi_cnt <= 16'h0000;
                end
                else if (is_cmd(s_cs_n, s_cmd, `DWS_CMD_ACT))
                    BANK_OPEN[s_ba] <= 1'b1;
                else if (is_cmd(s_cs_n, s_cmd, `DWS_CMD_PRE))
                begin
                    if (s_a10)
                        BANK_OPEN <= 8'h00;
                    else
                        BANK_OPEN[s_ba] <= 1'b0;
                end
                else if (is_cmd(s_cs_n, s_cmd, `DWS_CMD_WR))
                begin
                    // Writes to an idle bank, or beyond two in flight, are dropped.
                    if (!BANK_OPEN[s_ba])
                        CMD_ERROR <= 1'b1;
                    else if (!slot_v[0] || !slot_v[1])
                    begin
                        for (i = 1; i >= 0; i = i - 1)
                        begin
                            if (!slot_v[i] && (i == 0 || slot_v[0]))
                            begin
                                slot_v[i] <= 1'b1;
                                slot_cnt[i] <= wlat;
                                slot_col[i] <= s_col;
                                slot_chop[i] <= new_chop;
                            end
                        end
                        BURST_CHOP <= new_chop;
                    end
                    else
                        CMD_ERROR <= 1'b1;
                end
            end
        end
    end

    // Output stage keeps WR_VALID and WR_DATA straight from flops.
    always @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            WR_VALID <= 1'b0;
            WR_DATA <= {(DQ_W+3){1'b0}};
        end
        else if (CE && take_out)
        begin
            WR_VALID <= fifo_valid;
            WR_DATA <= fifo_data;
        end
    end

    dws_fifo #(
        .W(DQ_W + 3),
        .D(FIFO_D),
        .AW(2)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(rst_n),
        .ce(CE),
        .in_valid(push_v),
        .in_ready(fifo_ready),
        .in_data(push_d),
        .out_valid(fifo_valid),
        .out_ready(take_out),
        .out_data(fifo_data)
    );
endmodule
`default_nettype wire

// ### test/dws_core_properties.sv
/* Checker of the command engine's status and stream outputs, bound into dws_core.
   Assumes a single MCLK domain with RESETN as its asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
`include "dws_regs.vh"
module dws_core_props #(
    parameter DQ_W = 8,
    parameter REFI_NS = 7800
)
(
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RESETN,
    // Pins and mode.
    input wire logic CKE,
    input wire logic [1:0] BL_FIELD,
    // Write stream.
    input wire logic WR_VALID,
    input wire logic WR_READY,
    input wire logic [DQ_W+2:0] WR_DATA,
    // Status.
    input wire logic [7:0] BANK_OPEN,
    input wire logic SELF_REFRESH,
    input wire logic DLL_ENABLE,
    input wire logic DLL_RESET,
    input wire logic INT_REFRESH,
    input wire logic CMD_ERROR,
    input wire logic BURST_CHOP
);
    localparam int REFI_CYC = REFI_NS * `DWS_MCLK_MHZ / 1000;
    logic [15:0] gap;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    // Cycles in self refresh since the last internal refresh; a stalled timer shows here.
    always @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            gap <= 16'h0000;
        else if (INT_REFRESH || !SELF_REFRESH)
            gap <= 16'h0000;
        else
            gap <= gap + 16'h0001;
    end
    // The loop is back on while its reset pulse lasts a single cycle.
    sequence dll_back;
        DLL_ENABLE && !SELF_REFRESH ##1 !DLL_RESET;
    endsequence
    dll_off_a: assert property (SELF_REFRESH |-> !DLL_ENABLE)
        else $error("loop enabled in self refresh");
    dll_reset_a: assert property ($fell(SELF_REFRESH) |-> ##[0:1] DLL_RESET)
        else $error("no loop reset at exit");
    dll_pulse_a: assert property (DLL_RESET |-> dll_back)
        else $error("bad loop reset pulse");
    sr_entry_a: assert property ($rose(SELF_REFRESH) |-> !CKE ##[0:2] INT_REFRESH)
        else $error("bad self refresh entry");
    sr_exit_a: assert property ($fell(SELF_REFRESH) |-> CKE)
        else $error("exit without CKE high");
    refresh_gap_a: assert property (gap <= REFI_CYC + 2)
        else $error("internal refresh missing");
    sr_frozen_a: assert property (SELF_REFRESH && $past(SELF_REFRESH) |-> $stable(BANK_OPEN) && !CMD_ERROR)
        else $error("command acted on in self refresh");
    chop_on_a: assert property ($rose(BURST_CHOP) |-> BL_FIELD == `DWS_BL_OTF || BL_FIELD == `DWS_BL_FIX4)
        else $error("chop chosen in eight-beat mode");
    wr_hold_a: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_DATA))
        else $error("beat changed while stalled");
endmodule
bind dws_core dws_core_props #(.DQ_W(DQ_W), .REFI_NS(REFI_NS)) i_props (.MCLK(MCLK), .RESETN(RESETN),
    .CKE(CKE), .BL_FIELD(BL_FIELD), .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_DATA(WR_DATA),
    .BANK_OPEN(BANK_OPEN), .SELF_REFRESH(SELF_REFRESH), .DLL_ENABLE(DLL_ENABLE), .DLL_RESET(DLL_RESET),
    .INT_REFRESH(INT_REFRESH), .CMD_ERROR(CMD_ERROR), .BURST_CHOP(BURST_CHOP));
`default_nettype wire

// ### test/dws_ctl_model.sv
/* Controller model: free-running link clock, command slots and write strobes.
   Assumes the bench calls one task at a time, except two writes forked for gapless data. */
`timescale 1ns/1ps
`default_nettype none
`include "dws_regs.vh"
module dws_ctl_model (
    // Link clock and command pins.
    output logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic a10,
    output logic a12,
    output logic [2:0] col,
    output logic [2:0] ba,
    // Write strobe and data.
    output logic dqs,
    output logic [7:0] dq
);
    int act = 0;
    // No termination pin exists here, so termination stays off before every entry.
    // The clock must stay stable through self refresh, so it never stops.
    initial
    begin
        {cke, cs_n, ras_n, cas_n, we_n, a10, a12, col, ba} = 13'h1F00;
        {dqs, dq} = 9'h000;
        ck = 1'b0;
        #37;
        forever #100 ck = ~ck;
    end
    // One command slot centred on a rising edge, then deselect with the address flipped.
    task automatic cmd(input logic k, input logic [2:0] c, input logic h, input logic b12,
        input logic [2:0] cl, input logic [2:0] bk);
        @(negedge ck);
        cke = k;
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = c;
        {a10, a12, col, ba} = {h, b12, cl, bk};
        @(negedge ck);
        cs_n = 1'b1;
        {a10, a12, col, ba} = ~{a10, a12, col, ba};
    endtask
    // Write: a preamble only when no burst streams, so back-to-back data stays gapless.
    task automatic wr(input logic [2:0] bk, input logic [2:0] cl, input logic b12,
        input int n, input int wl, input logic [7:0] base);
        cmd(1'b1, `DWS_CMD_WR, 1'b0, b12, cl, bk);
        repeat (wl - 1) @(posedge ck);
        #50;
        if (act == 0) dqs = 1'b1;
        #100;
        if (act == 0) dqs = 1'b0;
        @(posedge ck);
        act++;
        for (int i = 0; i < n; i++)
        begin
            dq = base + 8'(i);
            #50 dqs = ~dqs;
            #50;
        end
        act--; // Strobe is left low as the postamble.
    endtask
endmodule
`default_nettype wire

// ### test/dws_core_test.sv
/* Testbench of dws_core: drives modes and the stream side and steers the controller model.
   Assumes the model and the bound checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "dws_regs.vh"
module dws_core_test;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic wr_ready = 1'b1;
    logic [1:0] bl_field = `DWS_BL_FIX8;
    logic [3:0] add_lat = 4'h0;
    logic [3:0] cas_wr_lat = 4'h5;
    wire ck, cke, cs_n, ras_n, cas_n, we_n, a10, a12, dqs;
    wire [2:0] col, ba;
    wire [7:0] dq, bank_open;
    wire [10:0] wr_data;
    wire wr_valid, self_refresh, dll_enable, dll_reset, int_refresh, cmd_error, burst_chop, overrun;
    logic [10:0] q[$];
    int num_errors = 0;
    int checked = 0;
    int n_err = 0;
    int n_ref = 0;
    int n_dllr = 0;
    // Exit, calibration and reference wait in CK clocks, kept as one count.
    localparam int XS_CK = 512;
    always #12.5 mclk = ~mclk;
    dws_ctl_model i_ctl (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .a10(a10), .a12(a12), .col(col), .ba(ba), .dqs(dqs), .dq(dq));
    dws_core #(.REFI_NS(500)) i_dut (.MCLK(mclk), .RESETN(resetn), .CE(1'b1), .CK(ck), .CKE(cke),
        .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .A10(a10), .A12(a12), .COL(col),
        .BA(ba), .DQS(dqs), .DQ(dq), .BL_FIELD(bl_field), .ADD_LAT(add_lat), .CAS_WR_LAT(cas_wr_lat),
        .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data), .BANK_OPEN(bank_open),
        .SELF_REFRESH(self_refresh), .DLL_ENABLE(dll_enable), .DLL_RESET(dll_reset),
        .INT_REFRESH(int_refresh), .CMD_ERROR(cmd_error), .BURST_CHOP(burst_chop), .OVERRUN(overrun));
    // Beats taken and one-cycle pulses are gathered at every edge, so none slips by.
    always @(posedge mclk)
    begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) q.push_back(wr_data);
        if (cmd_error === 1'b1) n_err++;
        if (int_refresh === 1'b1) n_ref++;
        if (dll_reset === 1'b1) n_dllr++;
    end
    // Case inequality, so an unknown never passes for a match.
    task check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // A command, then margin for the pin synchronisers and the status update.
    task c(input logic k, input logic [2:0] code, input logic h, input logic [2:0] bk);
        i_ctl.cmd(k, code, h, 1'b0, 3'h0, bk);
        repeat (4) @(posedge mclk);
        #2;
    endtask
    // Beats come out column first, eight wrapping in the block or four in the half.
    task burst(input logic [2:0] cl, input int n, input logic [7:0] base);
        logic [10:0] e;
        for (int i = 0; i < n; i++)
        begin
            e = (n == 4) ? {cl[2], cl[1:0] + 2'(i), base + 8'(i)} : {cl + 3'(i), base + 8'(i)};
            check((q.size() > 0) ? q.pop_front() : 11'hX, e);
        end
    endtask
    task wb(input logic [2:0] bk, input logic [2:0] cl, input logic b12, input int n, input logic [7:0] base);
        i_ctl.wr(bk, cl, b12, n, int'(add_lat) + int'(cas_wr_lat), base);
        repeat (8) @(posedge mclk);
        #2;
        burst(cl, n, base);
        check(q.size(), 0);
    endtask
    // Main sequence of scenarios.
    initial
    begin
        repeat (12) @(posedge mclk);
        #2 resetn = 1'b1;
        check({self_refresh, overrun, bank_open, dll_enable}, 32'h1);
        repeat (8) @(posedge mclk);
        #2;
        c(1'b1, `DWS_CMD_ACT, 1'b0, 3'h2);
        c(1'b1, `DWS_CMD_ACT, 1'b0, 3'h5);
        check(bank_open, 8'h24);
        wb(3'h2, 3'h5, 1'b0, 8, 8'h10);
        bl_field = `DWS_BL_OTF;
        fork
            i_ctl.wr(3'h2, 3'h6, 1'b1, 8, 5, 8'h20);
            begin
                repeat (4) @(negedge ck);
                i_ctl.wr(3'h5, 3'h1, 1'b1, 8, 5, 8'h30);
            end
        join
        repeat (8) @(posedge mclk);
        #2;
        burst(3'h6, 8, 8'h20);
        burst(3'h1, 8, 8'h30);
        check(burst_chop, 1'b0);
        wb(3'h5, 3'h6, 1'b0, 4, 8'h40);
        check(burst_chop, 1'b1);
        bl_field = `DWS_BL_FIX4;
        add_lat = 4'h2;
        wb(3'h2, 3'h3, 1'b1, 4, 8'h50);
        wb(3'h4, 3'h0, 1'b1, 0, 8'h00);
        check(n_err, 1);
        c(1'b1, `DWS_CMD_PRE, 1'b0, 3'h2);
        check(bank_open, 8'h20);
        c(1'b1, `DWS_CMD_ACT, 1'b0, 3'h6);
        c(1'b1, `DWS_CMD_PRE, 1'b1, 3'h3);
        check(bank_open, 8'h00);
        wb(3'h2, 3'h0, 1'b1, 0, 8'h00);
        check(n_err, 2);
        c(1'b0, `DWS_CMD_REF, 1'b0, 3'h0);
        check({self_refresh, dll_enable}, 2'h2);
        c(1'b0, `DWS_CMD_ACT, 1'b0, 3'h3);
        repeat (60) @(posedge mclk);
        #2;
        check(bank_open, 8'h00);
        check(n_ref >= 3, 1'b1);
        c(1'b1, 3'h7, 1'b0, 3'h0);
        check({self_refresh, dll_enable, n_dllr[1:0]}, 4'h5);
        repeat (XS_CK) @(posedge ck);
        #2;
        bl_field = 2'h3;
        c(1'b1, `DWS_CMD_ACT, 1'b0, 3'h1);
        wr_ready = 1'b0;
        i_ctl.wr(3'h1, 3'h0, 1'b1, 8, 7, 8'h60);
        repeat (8) @(posedge mclk);
        #2;
        check({overrun, wr_valid, burst_chop}, 3'h6);
        check(wr_data, 11'h060);
        wr_ready = 1'b1;
        repeat (20) @(posedge mclk);
        #2;
        q.delete();
        resetn = 1'b0;
        repeat (12) @(posedge mclk);
        #2 resetn = 1'b1;
        check({overrun, bank_open, dll_enable}, 32'h1);
        final_report();
    end
    // The run takes about 130 us; this cuts a hang short.
    initial
    begin
        #400000;
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
